// *** rtl/gpl_regs.svh ***
`ifndef GPL_REGS_SVH
`define GPL_REGS_SVH

// register byte offsets
`define GPL_OFS_DIRECTION    8'h00
`define GPL_OFS_INPUT_EN     8'h04
`define GPL_OFS_PULL_UP      8'h08
`define GPL_OFS_PULL_DOWN    8'h0c
`define GPL_OFS_OPEN_DRAIN   8'h10
`define GPL_OFS_DRIVE        8'h14
`define GPL_OFS_LOCK         8'h18
`define GPL_OFS_INPUT_DATA   8'h1c

// lock register fields
`define GPL_LOCK_KEY_MSB     31
`define GPL_LOCK_KEY_LSB     16
`define GPL_LOCK_KEY         16'h5fa0

// reset values
`define GPL_RST_WORD         32'h0000_0000
`define GPL_RST_PINS         16'h0000

`endif

// *** rtl/gpl_pkg.sv ***
package gpl_pkg;

  // per-pin configuration that the lock can freeze
  typedef struct packed {
    logic [15:0] direction;
    logic [15:0] input_en;
    logic [15:0] pull_up;
    logic [15:0] pull_down;
    logic [15:0] open_drain;
  } gpl_pin_cfg_t;

  // pad controls after priority resolution
  typedef struct packed {
    logic [15:0] pullup_en;
    logic [15:0] pulldown_en;
    logic [15:0] opendrain_en;
    logic [31:0] drive_code;
    logic [15:0] output_en;
  } gpl_pad_ctrl_t;

  // lock state handed to the alternate-function multiplexer
  typedef enum logic [0:0] {
    GPL_UNLOCKED = 1'b0,
    GPL_LOCKED   = 1'b1
  } gpl_lock_state_t;

endpackage

// *** rtl/gpl_port_pad_config_lock.sv ***
`timescale 1ns/1ps
`include "gpl_regs.svh"
// Overview of operation
// - pull-up select register, one bit per pin, 1 enables pull-up.
// - pull-down select register, one bit per pin, 1 enables pull-down.
// - pull-up wins; pull-down suppressed when both selected on a pin.
// - open-drain select register, 0 push-pull, 1 open-drain per pin.
// - two-bit drive code per pin, 00 lowest to 11 highest.
// - lock write accepted only with key 5fa0 in upper half; else discarded.
// - reading key field returns lock status, 0 inactive, 1 active.
// - lock register low half holds one lock bit per pin.
// - locked pin freezes direction, input enable, pulls, open-drain, alt-function.
// - lock register writable once, until reset.
// - direction bit 0 input, 1 output; frozen by lock.
// - input enable 0 forces sampled input to zero.
module gpl_port_pad_config_lock (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  // register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_write,
  input  wire logic                   reg_read,
  output logic [31:0]                 reg_rdata,
  // pad side
  input  wire logic [15:0]            pad_in,
  output gpl_pkg::gpl_pad_ctrl_t      pad_ctrl,
  output logic [15:0]                 pin_data_in,
  // toward the alternate-function multiplexer
  output logic [15:0]                 pin_lock_bits,
  output gpl_pkg::gpl_lock_state_t    lock_key_status
);
  import gpl_pkg::*;

  // configuration flops, one vector per field so each has its own process
  logic [15:0]  dir_bits;
  logic [15:0]  inen_bits;
  logic [15:0]  pu_bits;
  logic [15:0]  pd_bits;
  logic [15:0]  od_bits;

  // assembled view of the frozen fields, as the package lays them out
  gpl_pin_cfg_t cfg;

  // drive codes sit outside the lock
  logic [31:0]  pin_drive_code;

  // write word split into its two halves
  logic [15:0]  wdata_pins;
  logic [15:0]  key_field;

  // lock state and key check
  logic [15:0]  lock_bits;
  logic         locked;
  logic         key_match;
  logic         lock_accept;

  // write strobes decoded per offset
  logic         wr_direction;
  logic         wr_input_en;
  logic         wr_pull_up;
  logic         wr_pull_down;
  logic         wr_open_drain;
  logic         wr_drive;
  logic         wr_lock;

  // next values of the frozen fields, already masked by the lock
  logic [15:0]  next_dir;
  logic [15:0]  next_inen;
  logic [15:0]  next_pu;
  logic [15:0]  next_pd;
  logic [15:0]  next_od;

  // next values of the lock itself
  logic [15:0]  next_lock_bits;
  logic         next_locked;

  // pad control flops, one per field of the pad bundle
  logic [15:0]  pu_ctrl;
  logic [15:0]  pd_ctrl;
  logic [15:0]  od_ctrl;
  logic [31:0]  drv_ctrl;
  logic [15:0]  oe_ctrl;

  // input path and read path
  logic [15:0]  next_pulldown;
  logic [15:0]  next_sampled;
  logic [31:0]  lock_view;
  logic [31:0]  next_rdata;

  // writes only reach unlocked pins; one helper serves all five fields
  function automatic logic [15:0] masked_write(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [15:0] lk);
    masked_write = (old_v & lk) | (new_v & ~lk);
  endfunction

  // one write strobe aimed at one offset; all inputs passed in so it stays pure
  function automatic logic hit(input logic       wr,
                               input logic [7:0] addr,
                               input logic [7:0] ofs);
    hit = wr && (addr == ofs);
  endfunction

  // pull-up has priority, so a pin never sees both pulls at once
  function automatic logic [15:0] pull_down_gate(input logic [15:0] up,
                                                 input logic [15:0] down);
    pull_down_gate = down & ~up;
  endfunction

  // per-pin fields read back in the low half, upper half zero
  function automatic logic [31:0] low_half(input logic [15:0] v);
    low_half = {16'h0000, v};
  endfunction

  // low half carries pin bits, high half the key
  assign wdata_pins = reg_wdata[15:0];
  assign key_field  = reg_wdata[`GPL_LOCK_KEY_MSB:`GPL_LOCK_KEY_LSB];

  // offset decode for the write side
  // unmapped offsets match nothing and are dropped
  assign wr_direction  = hit(reg_write, reg_addr, `GPL_OFS_DIRECTION);
  assign wr_input_en   = hit(reg_write, reg_addr, `GPL_OFS_INPUT_EN);
  assign wr_pull_up    = hit(reg_write, reg_addr, `GPL_OFS_PULL_UP);
  assign wr_pull_down  = hit(reg_write, reg_addr, `GPL_OFS_PULL_DOWN);
  assign wr_open_drain = hit(reg_write, reg_addr, `GPL_OFS_OPEN_DRAIN);
  assign wr_drive      = hit(reg_write, reg_addr, `GPL_OFS_DRIVE);
  assign wr_lock       = hit(reg_write, reg_addr, `GPL_OFS_LOCK);

  // locked pins keep their old bits whatever software writes
  assign next_dir  = masked_write(dir_bits, wdata_pins, lock_bits);
  assign next_inen = masked_write(inen_bits, wdata_pins, lock_bits);
  assign next_pu   = masked_write(pu_bits, wdata_pins, lock_bits);
  assign next_pd   = masked_write(pd_bits, wdata_pins, lock_bits);
  assign next_od   = masked_write(od_bits, wdata_pins, lock_bits);

  // the frozen fields in the order the package expects
  assign cfg = {dir_bits, inen_bits, pu_bits, pd_bits, od_bits};

  // direction: 0 input, 1 output
  // a locked pin keeps its mode, so a stray write cannot turn it around
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dir_bits <= `GPL_RST_PINS;
    end else if (wr_direction) begin
      dir_bits <= next_dir;
    end
  end

  // input enable: 0 switches the receiver off
  // frozen like direction, so a locked input cannot go deaf
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      inen_bits <= `GPL_RST_PINS;
    end else if (wr_input_en) begin
      inen_bits <= next_inen;
    end
  end

  // pull-up select
  // locked pins ignore the write bit for bit
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pu_bits <= `GPL_RST_PINS;
    end else if (wr_pull_up) begin
      pu_bits <= next_pu;
    end
  end

  // pull-down select; the pad only sees it where no pull-up is set
  // stored as written, so software reads back what it wrote
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pd_bits <= `GPL_RST_PINS;
    end else if (wr_pull_down) begin
      pd_bits <= next_pd;
    end
  end

  // open-drain select: 0 push-pull, 1 open-drain
  // frozen too, so a locked shared line keeps its output type
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      od_bits <= `GPL_RST_PINS;
    end else if (wr_open_drain) begin
      od_bits <= next_od;
    end
  end

  // drive codes, two bits per pin, 00 weakest to 11 strongest
  // kept free on purpose: software may retune a locked pin's current
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_drive_code <= `GPL_RST_WORD;
    end else if (wr_drive) begin
      pin_drive_code <= reg_wdata;
    end
  end

  // the key must arrive in the same write as the lock bits
  assign key_match      = (key_field == `GPL_LOCK_KEY);
  assign lock_accept    = wr_lock && !locked && key_match;
  assign next_lock_bits = lock_accept ? wdata_pins : lock_bits;
  assign next_locked    = locked | lock_accept;

  // lock bits: one accepted write, then sealed until reset
  // a second keyed write is ignored, even with the right key
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lock_bits <= `GPL_RST_PINS;
    end else begin
      lock_bits <= next_lock_bits;
    end
  end

  // sealed flag; only reset clears it, so a runaway write cannot unlock
  // rst_n doubles as the port reset here
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      locked <= 1'b0;
    end else begin
      locked <= next_locked;
    end
  end

  // pads see the resolved pulls, never the raw pull-down select
  assign next_pulldown = pull_down_gate(cfg.pull_up, cfg.pull_down);

  // pull-up control to the pad
  // one flop stage, so pads follow a write two edges after the strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pu_ctrl <= `GPL_RST_PINS;
    end else begin
      pu_ctrl <= cfg.pull_up;
    end
  end

  // pull-down control to the pad
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pd_ctrl <= `GPL_RST_PINS;
    end else begin
      pd_ctrl <= next_pulldown;
    end
  end

  // output type to the pad
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      od_ctrl <= `GPL_RST_PINS;
    end else begin
      od_ctrl <= cfg.open_drain;
    end
  end

  // drive level to the pad
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      drv_ctrl <= `GPL_RST_WORD;
    end else begin
      drv_ctrl <= pin_drive_code;
    end
  end

  // output enable follows direction; high while the pin drives
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      oe_ctrl <= `GPL_RST_PINS;
    end else begin
      oe_ctrl <= cfg.direction;
    end
  end

  // pad bundle straight from the five flops above
  assign pad_ctrl = {pu_ctrl, pd_ctrl, od_ctrl, drv_ctrl, oe_ctrl};

  // receiver off reads zero; inputs are taken as synchronous
  assign next_sampled = pad_in & cfg.input_en;

  // sampled input, one flop deep
  // no synchroniser: pins are taken as synchronous to clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_data_in <= `GPL_RST_PINS;
    end else begin
      pin_data_in <= next_sampled;
    end
  end

  // lock bits copied out for the alt-function select fields
  // the multiplexer freezes its select fields with these
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_lock_bits <= `GPL_RST_PINS;
    end else begin
      pin_lock_bits <= lock_bits;
    end
  end

  // lock state for the same fields
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lock_key_status <= GPL_UNLOCKED;
    end else begin
      lock_key_status <= locked ? GPL_LOCKED : GPL_UNLOCKED;
    end
  end

  // key field reads back as the lock status, not the key
  assign lock_view = {15'h0, locked, lock_bits};

  // read mux; unmapped offsets read zero
  // fields narrower than a word read back zero-extended
  always_comb begin
    next_rdata = `GPL_RST_WORD;
    case (reg_addr)
      `GPL_OFS_DIRECTION:  next_rdata = low_half(cfg.direction);
      `GPL_OFS_INPUT_EN:   next_rdata = low_half(cfg.input_en);
      `GPL_OFS_PULL_UP:    next_rdata = low_half(cfg.pull_up);
      `GPL_OFS_PULL_DOWN:  next_rdata = low_half(cfg.pull_down);
      `GPL_OFS_OPEN_DRAIN: next_rdata = low_half(cfg.open_drain);
      `GPL_OFS_DRIVE:      next_rdata = pin_drive_code;
      `GPL_OFS_LOCK:       next_rdata = lock_view;
      `GPL_OFS_INPUT_DATA: next_rdata = low_half(pin_data_in);
      default:             next_rdata = `GPL_RST_WORD;
    endcase
  end

  // read data valid the cycle after the strobe only, zero otherwise
  // the idle zero keeps stale data off the bus between reads
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= `GPL_RST_WORD;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= `GPL_RST_WORD;
    end
  end

endmodule

// *** verification/gpl_lock_monitor.sv ***
`timescale 1ns/1ps
// sees the top ports only; pad controls trail a write by two edges
module gpl_lock_monitor import gpl_pkg::*; (
  // clock, reset, register port
  input logic clock, rst_n, reg_write, reg_read,
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata, reg_rdata,
  // pad and lock side
  input logic [15:0] pad_in, pin_data_in, pin_lock_bits,
  input gpl_pad_ctrl_t pad_ctrl,
  input gpl_lock_state_t lock_key_status
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // lock write decode and port state
  wire lk_wr = reg_write && reg_addr == 8'h18;
  wire key_ok = reg_wdata[31:16] == 16'h5fa0;
  wire unl = lock_key_status == GPL_UNLOCKED;
  a_pull_up_wins: assert property ((pad_ctrl.pullup_en & pad_ctrl.pulldown_en) == 16'h0)
    else $error("pull clash");
  a_key_gate: assert property (lk_wr && !key_ok |-> ##2 $stable(pin_lock_bits) && $stable(lock_key_status))
    else $error("bad key took");
  a_key_locks: assert property (unl && lk_wr && key_ok && !$past(lk_wr && key_ok) |-> ##2 !unl &&
    pin_lock_bits == $past(reg_wdata[15:0], 2))
    else $error("lock missed");
  a_lock_sticks: assert property (!unl |=> !unl && $stable(pin_lock_bits))
    else $error("lock moved");
  a_status_read: assert property (reg_read && reg_addr == 8'h18 |=> reg_rdata[31:16] == {15'h0, !unl})
    else $error("status read");
  a_dir_to_oe: assert property (unl && !$past(lk_wr) && reg_write && reg_addr == 8'h0 |-> ##2
    pad_ctrl.output_en == $past(reg_wdata[15:0], 2))
    else $error("dir lost");
  a_drive_free: assert property (reg_write && reg_addr == 8'h14 |-> ##2 pad_ctrl.drive_code == $past(reg_wdata, 2))
    else $error("drive lost");
  a_frozen_pu: assert property (reg_write && reg_addr == 8'h8 |-> ##2
    ((pad_ctrl.pullup_en ^ $past(pad_ctrl.pullup_en, 2)) & pin_lock_bits) == 16'h0)
    else $error("locked pull moved");
endmodule
bind gpl_port_pad_config_lock gpl_lock_monitor mon (.clock, .rst_n, .reg_write, .reg_read, .reg_addr, .reg_wdata,
  .reg_rdata, .pad_in, .pin_data_in, .pin_lock_bits, .pad_ctrl, .lock_key_status);

// *** verification/gpl_testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import gpl_pkg::*;
  logic clock, rst_n, reg_write, reg_read;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] pad_in, pin_data_in, pin_lock_bits;
  gpl_pad_ctrl_t pad_ctrl;
  gpl_lock_state_t lock_key_status;
  int n_errors = 0;
  int samples_checked = 0;
  gpl_port_pad_config_lock DUT (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .pad_in, .pad_ctrl, .pin_data_in, .pin_lock_bits, .lock_key_status);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobe taken at the second edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock); reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
    @(posedge clock); reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock); reg_addr <= a; reg_read <= 1'b1;
    @(posedge clock); reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task settle;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task t_reset;
    for (int a = 0; a <= 32; a += 4) rd(a[7:0], 32'h0);
  endtask
  task t_pads;
    wr(8'h8, 32'hff); wr(8'hc, 32'hff0); wr(8'h10, 32'h8001); wr(8'h14, 32'he4e4e4e4); wr(8'h0, 32'h2);
    settle;
    chk(pad_ctrl.pullup_en, 32'hff);
    chk(pad_ctrl.pulldown_en, 32'hf00);
    chk(pad_ctrl.opendrain_en, 32'h8001);
    chk(pad_ctrl.drive_code, 32'he4e4e4e4);
    rd(8'hc, 32'hff0);
  endtask
  task t_lock;
    wr(8'h18, 32'h12340003); rd(8'h18, 32'h0);
    wr(8'h18, 32'h5fa00003); rd(8'h18, 32'h10003);
    wr(8'h18, 32'h5fa0ffff); rd(8'h18, 32'h10003);
    wr(8'h0, 32'hfffd); wr(8'h8, 32'h0); wr(8'h14, 32'h0);
    settle;
    chk(pad_ctrl.output_en, 32'hfffe);
    rd(8'h8, 32'h3);
    rd(8'h14, 32'h0);
    chk(pin_lock_bits, 32'h3);
    chk(lock_key_status, 32'h1);
  endtask
  task t_input;
    @(posedge clock); pad_in <= 16'hffff;
    wr(8'h4, 32'hf3);
    settle;
    chk(pin_data_in, 32'hf0);
    rd(8'h1c, 32'hf0);
  endtask
  // a mid-run reset is the only way out of the lock
  task t_rerst;
    @(posedge clock); rst_n <= 1'b0;
    repeat (2) @(posedge clock); rst_n <= 1'b1;
    rd(8'h18, 32'h0);
    chk(lock_key_status, 32'h0);
    chk(pad_ctrl.output_en, 32'h0);
  endtask
  task final_report;
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // the run needs well under 2000 ns
  initial begin
    #20000;
    n_errors++;
    final_report;
  end
  initial begin
    rst_n = 1'b0; reg_write = 1'b0; reg_read = 1'b0; reg_addr = 8'h0; reg_wdata = 32'h0; pad_in = 16'h0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset; t_pads; t_lock; t_input; t_rerst;
    final_report;
  end
endmodule
